// [logic/fsr_pkg.sv]
package fsr_pkg;

	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_READ_LOW  = 8'h05;
	localparam logic [7:0] OP_READ_HIGH = 8'h35;

	// ************************************************************
	// Status byte low fields
	// ************************************************************
	localparam int LOW_GUARD0_POS = 7;
	localparam int LOW_GRAN_POS   = 6;
	localparam int LOW_TB_POS     = 5;
	localparam int LOW_LEVEL_POS  = 2;
	localparam int LOW_WEL_POS    = 1;
	localparam int LOW_BUSY_POS   = 0;
	localparam logic [7:0] LOW_WRITE_MASK = 8'hFC;
	localparam logic [7:0] LOW_RESET      = 8'h00;

	// ************************************************************
	// Status byte high fields
	// ************************************************************
	localparam int HIGH_INVERT_POS = 6;
	localparam int HIGH_LOCK1_POS  = 3;
	localparam int HIGH_QE_POS     = 1;
	localparam int HIGH_GUARD1_POS = 0;
	localparam logic [7:0] HIGH_WRITE_MASK = 8'h7B;
	localparam logic [7:0] HIGH_RESET      = 8'h00;

	// ************************************************************
	// Serial timing
	// ************************************************************
	localparam logic [2:0] BIT_FIRST = 3'h7;
	localparam logic [2:0] CNT_OPCODE_DONE = 3'h7;

	// ************************************************************
	// Serial state machine
	// ************************************************************
	typedef enum logic [1:0] {
		FSR_IDLE = 2'b00,
		FSR_OPC  = 2'b01,
		FSR_SEND = 2'b11,
		FSR_SKIP = 2'b10
	} fsr_state_type;

endpackage

// [logic/fsr_sync.sv]
`timescale 1ns/1ns
module fsr_sync #(
	parameter int WIDTH = 3
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} fsr_sync_type;

	fsr_sync_type st_r;
	fsr_sync_type st_nxt;

	// ************************************************************
	// Two-flop synchroniser
	// ************************************************************
	always_comb begin
		st_nxt        = st_r;
		st_nxt.stage1 = async_in;
		st_nxt.stage2 = st_r.stage1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sync_out = st_r.stage2;

endmodule

// [logic/fsr_status_read.sv]
// Functional notes
// - Status reads served any time, even busy
// - Opcode 05h returns status byte low
// - After bit 0 wrap to bit 7
// - Each pass resamples live status
// - Chip select release ends read, output floats
// - Opcode 35h returns status byte high
// - Low byte guard0, granularity, top, level bits
// - Low bit 1 is read-only write latch
// - Low bit 0 is read-only busy
// - Writes change only low bits 7..2
// - High bits 7 and 2 read zero
// - High bit 6 protect invert, default zero
// - High bits 5..3 otp page locks
// - High bit 1 quad enable, pin roles
// - High bit 0 status guard 1
// - Writes change only high bits 6..3,1,0
`timescale 1ns/1ns
module fsr_status_read (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Serial pins
	input  wire logic       spi_clk,
	input  wire logic       chip_sel_n,
	input  wire logic       serial_in,
	output logic            serial_out,
	output logic            serial_out_en,
	// Core status inputs
	input  wire logic       busy_flag,
	input  wire logic       write_latch_flag,
	// Write-status port from command decoder
	input  wire logic       wr_low_stb,
	input  wire logic [7:0] wr_low_data,
	input  wire logic       wr_high_stb,
	input  wire logic [7:0] wr_high_data,
	// Status field outputs
	output logic            status_guard_0,
	output logic            status_guard_1,
	output logic            block_granularity_select,
	output logic            top_bottom_select,
	output logic [2:0]      protect_level,
	output logic            protect_invert,
	output logic [2:0]      otp_lock_page,
	output logic            quad_io_enable
);

	typedef struct packed {
		fsr_pkg::fsr_state_type state;
		logic                   clk_d;
		logic [2:0]             cnt;
		logic [7:0]             opcode;
		logic                   sel_high;
		logic [7:0]             shift;
		logic [7:0]             low_w;
		logic [7:0]             high_w;
		logic                   so;
		logic                   so_en;
	} fsr_core_type;

	fsr_core_type st_r;
	fsr_core_type st_nxt;

	logic       clk_s;
	logic       csn_s;
	logic       si_s;
	logic       rise;
	logic       fall;
	logic [7:0] live_low;
	logic [7:0] live_high;
	logic [7:0] live_sel;
	logic [7:0] opc_next;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	fsr_sync #(
		.WIDTH(3)
	) u_sync (
		.sys_clk  (sys_clk),
		.rst_n    (rst_n),
		.async_in ({spi_clk, chip_sel_n, serial_in}),
		.sync_out ({clk_s, csn_s, si_s})
	);

	// ************************************************************
	// Live status bytes
	// ************************************************************
	always_comb begin
		live_low  = st_r.low_w & fsr_pkg::LOW_WRITE_MASK;
		live_low[fsr_pkg::LOW_WEL_POS]  = write_latch_flag;
		live_low[fsr_pkg::LOW_BUSY_POS] = busy_flag;
		live_high = st_r.high_w & fsr_pkg::HIGH_WRITE_MASK;
		live_sel  = st_r.sel_high ? live_high : live_low;
	end

	assign rise     = clk_s & ~st_r.clk_d;
	assign fall     = ~clk_s & st_r.clk_d;
	assign opc_next = {st_r.opcode[6:0], si_s};

	// ************************************************************
	// Serial engine and register writes
	// ************************************************************
	always_comb begin
		st_nxt       = st_r;
		st_nxt.clk_d = clk_s;
		if (wr_low_stb) begin
			st_nxt.low_w = (st_r.low_w & ~fsr_pkg::LOW_WRITE_MASK)
				| (wr_low_data & fsr_pkg::LOW_WRITE_MASK);
		end
		if (wr_high_stb) begin
			st_nxt.high_w = (st_r.high_w & ~fsr_pkg::HIGH_WRITE_MASK)
				| (wr_high_data & fsr_pkg::HIGH_WRITE_MASK);
		end
		if (csn_s) begin
			st_nxt.state  = fsr_pkg::FSR_IDLE;
			st_nxt.so_en  = 1'b0;
			st_nxt.so     = 1'b0;
			st_nxt.cnt    = '0;
			st_nxt.opcode = '0;
		end else begin
			case (st_r.state)
				fsr_pkg::FSR_IDLE: begin
					st_nxt.state = fsr_pkg::FSR_OPC;
					st_nxt.cnt   = '0;
				end
				fsr_pkg::FSR_OPC: begin
					if (rise) begin
						st_nxt.opcode = opc_next;
						st_nxt.cnt    = st_r.cnt + 3'h1;
						if (st_r.cnt == fsr_pkg::CNT_OPCODE_DONE) begin
							if (opc_next == fsr_pkg::OP_READ_LOW) begin
								st_nxt.state    = fsr_pkg::FSR_SEND;
								st_nxt.sel_high = 1'b0;
							end else if (opc_next == fsr_pkg::OP_READ_HIGH) begin
								st_nxt.state    = fsr_pkg::FSR_SEND;
								st_nxt.sel_high = 1'b1;
							end else begin
								st_nxt.state = fsr_pkg::FSR_SKIP;
							end
							st_nxt.cnt = fsr_pkg::BIT_FIRST;
						end
					end
				end
				fsr_pkg::FSR_SEND: begin
					if (fall) begin
						if (st_r.cnt == fsr_pkg::BIT_FIRST) begin
							st_nxt.shift = live_sel;
							st_nxt.so    = live_sel[7];
						end else begin
							st_nxt.so = st_r.shift[st_r.cnt];
						end
						st_nxt.so_en = 1'b1;
						st_nxt.cnt   = st_r.cnt - 3'h1;
					end
				end
				fsr_pkg::FSR_SKIP: begin
					st_nxt.so_en = 1'b0;
				end
				default: begin
					st_nxt.state = fsr_pkg::FSR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r        <= '0;
			st_r.state  <= fsr_pkg::FSR_IDLE;
			st_r.low_w  <= fsr_pkg::LOW_RESET;
			st_r.high_w <= fsr_pkg::HIGH_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign serial_out    = st_r.so;
	assign serial_out_en = st_r.so_en;
	assign status_guard_0 = st_r.low_w[fsr_pkg::LOW_GUARD0_POS];
	assign block_granularity_select = st_r.low_w[fsr_pkg::LOW_GRAN_POS];
	assign top_bottom_select = st_r.low_w[fsr_pkg::LOW_TB_POS];
	assign protect_level = st_r.low_w[fsr_pkg::LOW_LEVEL_POS +: 3];
	assign protect_invert = st_r.high_w[fsr_pkg::HIGH_INVERT_POS];
	assign otp_lock_page = st_r.high_w[fsr_pkg::HIGH_LOCK1_POS +: 3];
	assign quad_io_enable = st_r.high_w[fsr_pkg::HIGH_QE_POS];
	assign status_guard_1 = st_r.high_w[fsr_pkg::HIGH_GUARD1_POS];

	// ************************************************************
	// Checks
	// ************************************************************
	a_float_on_release: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		csn_s |=> !serial_out_en)
		else $error("output driven after deselect");

	a_release_idle: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		csn_s |=> st_r.state == fsr_pkg::FSR_IDLE)
		else $error("read not ended on deselect");

	a_low_fixed_bits: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		wr_low_stb |=> st_r.low_w[1:0] == $past(st_r.low_w[1:0]))
		else $error("low byte bits 1..0 changed by write");

	a_low_write_taken: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		wr_low_stb |=> st_r.low_w[7:2] == $past(wr_low_data[7:2]))
		else $error("low byte write lost");

	a_high_reserved_zero: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!live_high[7] && !live_high[2])
		else $error("reserved high bit set");

	a_high_fixed_bits: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		wr_high_stb |=> st_r.high_w[7] == $past(st_r.high_w[7])
			&& st_r.high_w[2] == $past(st_r.high_w[2]))
		else $error("reserved high bits changed by write");

	a_high_write_taken: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		wr_high_stb |=> st_r.high_w[6:3] == $past(wr_high_data[6:3])
			&& st_r.high_w[1:0] == $past(wr_high_data[1:0]))
		else $error("high byte write lost");

	a_bytes_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		!wr_low_stb && !wr_high_stb
			|=> $stable(st_r.low_w) && $stable(st_r.high_w))
		else $error("status byte changed without write");

	a_busy_live: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		live_low[0] == busy_flag && live_low[1] == write_latch_flag)
		else $error("flags not live in low byte");

	a_opc_silent: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		st_r.state == fsr_pkg::FSR_OPC |-> !serial_out_en)
		else $error("output driven during opcode");

	a_opcode_shift: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_OPC && !csn_s && rise)
			|=> st_r.opcode[0] == $past(si_s))
		else $error("opcode bit not taken on rise");

	a_count_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_OPC && !csn_s && !rise)
			|=> $stable(st_r.cnt))
		else $error("opcode count moved without rise");

	a_opcode_low: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_OPC && !csn_s && rise
			&& st_r.cnt == 3'h7 && opc_next == 8'h05)
			|=> st_r.state == fsr_pkg::FSR_SEND && !st_r.sel_high)
		else $error("opcode 05h not accepted");

	a_opcode_high: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_OPC && !csn_s && rise
			&& st_r.cnt == 3'h7 && opc_next == 8'h35)
			|=> st_r.state == fsr_pkg::FSR_SEND && st_r.sel_high)
		else $error("opcode 35h not accepted");

	a_opcode_skip: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_OPC && !csn_s && rise
			&& st_r.cnt == 3'h7 && opc_next != 8'h05
			&& opc_next != 8'h35)
			|=> st_r.state == fsr_pkg::FSR_SKIP)
		else $error("unknown opcode not refused");

	a_skip_silent: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		st_r.state == fsr_pkg::FSR_SKIP |-> !serial_out_en)
		else $error("output driven after unknown opcode");

	a_enable_on_fall: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_SEND && !csn_s && fall)
			|=> serial_out_en)
		else $error("output not enabled on fall");

	a_wrap_reload: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_SEND && !csn_s && fall
			&& st_r.cnt == 3'h0) |=> st_r.cnt == 3'h7)
		else $error("no wrap to bit 7");

	a_fresh_sample: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_SEND && !csn_s && fall
			&& st_r.cnt == 3'h7) |=> st_r.shift == $past(live_sel))
		else $error("pass not resampled");

	a_first_bit: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_SEND && !csn_s && fall
			&& st_r.cnt == 3'h7)
			|=> serial_out == $past(live_sel[7]))
		else $error("bit 7 not from fresh byte");

	a_bit_order: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_SEND && !csn_s && fall
			&& st_r.cnt != 3'h7)
			|=> serial_out == $past(st_r.shift[st_r.cnt]))
		else $error("status bit out of order");

	a_output_hold: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_r.state == fsr_pkg::FSR_SEND && !csn_s && !fall)
			|=> $stable(serial_out))
		else $error("output changed without falling edge");

	a_select_kept: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		st_r.state == fsr_pkg::FSR_SEND |=> $stable(st_r.sel_high))
		else $error("byte selection changed during read");

endmodule

// [tb/fsr_host_model.sv]
`timescale 1ns/1ns
module fsr_host_model (
	// Clock
	input  wire logic sys_clk,
	// Serial pins
	output logic      spi_clk,
	output logic      chip_sel_n,
	output logic      serial_in,
	input  wire logic serial_out,
	input  wire logic serial_out_en
);
	initial begin
		spi_clk = 1'b0;
		chip_sel_n = 1'b1;
		serial_in = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// ************************************************************
	// One frame: opcode, then n bits taken, then release
	// ************************************************************
	task automatic frame(input logic [7:0] op, input int n,
		output logic [15:0] rx, output logic en_any);
		rx = 16'h0000;
		en_any = 1'b0;
		@(posedge sys_clk);
		chip_sel_n <= 1'b0;
		tick(5);
		for (int i = 7; i >= 0; i--) begin
			serial_in <= op[i];
			tick(4);
			spi_clk <= 1'b1;
			tick(4);
			spi_clk <= 1'b0;
		end
		for (int k = 0; k < n; k++) begin
			serial_in <= ~serial_in;
			tick(4);
			spi_clk <= 1'b1;
			tick(4);
			rx = {rx[14:0], serial_out};
			en_any = en_any | serial_out_en;
			spi_clk <= 1'b0;
		end
		tick(4);
		chip_sel_n <= 1'b1;
		tick(6);
	endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	logic        sys_clk, rst_n, spi_clk, chip_sel_n, serial_in;
	logic        serial_out, serial_out_en, busy_flag, write_latch_flag;
	logic        wr_low_stb, wr_high_stb, g0, g1, gran, tbs, inv, qe;
	logic [7:0]  wr_low_data, wr_high_data, fl, fh, e;
	logic [2:0]  lvl, otp;
	logic [15:0] rx;
	logic        en_any;
	logic [8:0]  wtab [5] = '{9'h0FF, 9'h0A9, 9'h1FF, 9'h184, 9'h152};
	int          bad_count, checks_done;

	assign fl = {g0, gran, tbs, lvl, 2'b00};
	assign fh = {1'b0, inv, otp, 1'b0, qe, g1};

	fsr_status_read dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.spi_clk(spi_clk), .chip_sel_n(chip_sel_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_en(serial_out_en),
		.busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
		.wr_low_stb(wr_low_stb), .wr_low_data(wr_low_data),
		.wr_high_stb(wr_high_stb), .wr_high_data(wr_high_data),
		.status_guard_0(g0), .status_guard_1(g1),
		.block_granularity_select(gran), .top_bottom_select(tbs),
		.protect_level(lvl), .protect_invert(inv), .otp_lock_page(otp),
		.quad_io_enable(qe));

	fsr_host_model host (.sys_clk(sys_clk), .spi_clk(spi_clk),
		.chip_sel_n(chip_sel_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_en(serial_out_en));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic hi, input logic [7:0] d);
		@(posedge sys_clk);
		wr_low_stb <= !hi;
		wr_high_stb <= hi;
		wr_low_data <= d;
		wr_high_data <= d;
		@(posedge sys_clk);
		wr_low_stb <= 1'b0;
		wr_high_stb <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic stop_test;
		$display("Checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#400000;
		bad_count++;
		$display("Error at %0t: run timed out", $time);
		stop_test();
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		rst_n = 1'b0;
		busy_flag = 1'b1;
		write_latch_flag = 1'b0;
		wr_low_stb = 1'b0;
		wr_high_stb = 1'b0;
		wr_low_data = 8'h00;
		wr_high_data = 8'h00;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		check({fl, fh}, 16'h0000);
		check({15'h0000, serial_out_en}, 16'h0000);
		host.frame(8'h05, 16, rx, en_any);
		check(rx, 16'h0101);
		check({15'h0000, en_any}, 16'h0001);
		check({15'h0000, serial_out_en}, 16'h0000);
		$display("Done: busy read");
		write_latch_flag <= 1'b1;
		fork
			host.frame(8'h05, 16, rx, en_any);
			begin
				repeat (110) @(posedge sys_clk);
				busy_flag <= 1'b0;
			end
		join
		check(rx, 16'h0302);
		$display("Done: live resample");
		write_latch_flag <= 1'b0;
		host.frame(8'h9F, 8, rx, en_any);
		check({15'h0000, en_any}, 16'h0000);
		$display("Done: unknown opcode");
		for (int i = 0; i < 5; i++) begin
			wr(wtab[i][8], wtab[i][7:0]);
			e = wtab[i][7:0] & (wtab[i][8] ? 8'h7B : 8'hFC);
			check({8'h00, wtab[i][8] ? fh : fl}, {8'h00, e});
			host.frame(wtab[i][8] ? 8'h35 : 8'h05, 12, rx, en_any);
			check(rx, {4'h0, e, e[7:4]});
			check({15'h0000, serial_out_en}, 16'h0000);
		end
		$display("Done: write and read back");
		stop_test();
	end
endmodule
